//--- test/fdp_mac_properties.sv
`include "fdp_defs.svh"

module fdp_mac_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // issue slot
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] src_one,
  input wire logic [63:0] src_two,
  input wire logic dsp_enable,
  input wire logic acc_wr_en,
  // results
  input wire logic [1:0] acc_rd_sel,
  input wire logic [63:0] acc_rd_hi,
  input wire logic [63:0] acc_rd_lo,
  input wire logic [3:0] flag_clr,
  input wire logic [3:0] ovf_flag,
  input wire logic exc_reserved,
  input wire logic exc_dsp_disabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ours;    // one of the four encodings, pad not judged
  logic pad_ok;  // three bits above the select field are zero
  logic quad;    // legal quad halfword issue
  // decode kept apart from the design so a shared slip cannot hide
  assign ours = instr_valid && instr_word[31:26] == 6'h1f
    && (instr_word[5:0] == 6'h30 || instr_word[5:0] == 6'h34)
    && (instr_word[10:6] == 5'h04 || instr_word[10:6] == 5'h0c);
  assign pad_ok = instr_word[15:13] == 3'h0;
  assign quad = ours && pad_ok && dsp_enable && instr_word[5:0] == 6'h34
    && instr_word[10:6] == 5'h04;

  a_pad_refused: assert property (ours && !pad_ok |=> exc_reserved)
    else $error("bad pad field not refused");
  a_disabled_raised: assert property (ours && pad_ok && !dsp_enable |=> exc_dsp_disabled)
    else $error("disabled exception missing");
  a_no_data_exc: assert property (exc_reserved || exc_dsp_disabled |-> $past(ours))
    else $error("exception without cause");
  a_foreign_quiet: assert property (instr_valid && !ours |=> !exc_reserved)
    else $error("foreign word raised exception");
  a_q15_flag: assert property (quad && src_one[15:0] == 16'h8000
    && src_two[15:0] == 16'h8000 |=> ovf_flag[$past(instr_word[12:11])])
    else $error("minus one squared left no flag");
  a_quad_no_flag: assert property (quad && src_one == 64'h0 && flag_clr == 4'hf
    |=> ovf_flag == 4'h0)
    else $error("quad set flag without saturation");
  a_flag_sticky: assert property (1'b1 |=>
    (~ovf_flag & $past(ovf_flag) & ~$past(flag_clr)) == 4'h0)
    else $error("flag dropped without clear");
  a_rd_holds: assert property (!instr_valid && !acc_wr_en && $stable(acc_rd_sel)
    |=> $stable(acc_rd_hi) && $stable(acc_rd_lo))
    else $error("accumulator moved while idle");
endmodule : fdp_mac_properties

bind fdp_mac fdp_mac_properties fdp_mac_properties_inst (.clk(clk), .arst_n(arst_n),
  .instr_valid(instr_valid), .instr_word(instr_word), .src_one(src_one),
  .src_two(src_two), .dsp_enable(dsp_enable), .acc_wr_en(acc_wr_en),
  .acc_rd_sel(acc_rd_sel), .acc_rd_hi(acc_rd_hi), .acc_rd_lo(acc_rd_lo),
  .flag_clr(flag_clr), .ovf_flag(ovf_flag), .exc_reserved(exc_reserved),
  .exc_dsp_disabled(exc_dsp_disabled));

//--- test/fdp_pipe_model.sv
module fdp_pipe_model (
  // clock
  input wire logic clk,
  // issue slot toward the datapath
  output logic instr_valid,
  output logic [31:0] instr_word,
  output logic [63:0] src_one,
  output logic [63:0] src_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle slot at power up
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
    src_one = 64'h0;
    src_two = 64'h0;
  end
  // hold one word for n cycles; idle slot shows inverted junk, never stale data
  task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
    input int n);
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr_word = w;
    src_one = a;
    src_two = b;
    repeat (n) @(posedge clk);
    #1;
    instr_valid = 1'b0;
    instr_word = ~w;
    src_one = ~a;
    src_two = ~b;
  endtask : issue
endmodule : fdp_pipe_model

//--- test/fractional_dot_product_mac_bench.sv
module fractional_dot_product_mac_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, dsp_enable = 1'b1, acc_wr_en = 1'b0;
  logic [1:0] acc_wr_sel = 2'h0, acc_rd_sel = 2'h0;
  logic [63:0] acc_wr_hi = 64'h0, acc_wr_lo = 64'h0, acc_rd_hi, acc_rd_lo, s1, s2;
  logic [31:0] instr_word;
  logic instr_valid, exc_reserved, exc_dsp_disabled;
  logic [3:0] flag_clr = 4'h0, ovf_flag;
  int n_fail = 0, checks = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
  always #20 clk = ~clk;
  fdp_pipe_model fdp_pipe_model_inst (.clk(clk), .instr_valid(instr_valid),
    .instr_word(instr_word), .src_one(s1), .src_two(s2));
  fdp_mac fdp_mac_inst (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .src_one(s1), .src_two(s2), .dsp_enable(dsp_enable),
    .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel), .acc_wr_hi(acc_wr_hi),
    .acc_wr_lo(acc_wr_lo), .acc_rd_sel(acc_rd_sel), .acc_rd_hi(acc_rd_hi),
    .acc_rd_lo(acc_rd_lo), .flag_clr(flag_clr), .ovf_flag(ovf_flag),
    .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));
  // instruction word from function, sub-operation, pair and pad field
  function automatic logic [31:0] enc(input logic [5:0] fn, input logic [4:0] sb,
    input logic [1:0] ac, input logic [2:0] pad);
    return {6'h1f, 5'h01, 5'h02, pad, ac, sb, fn};
  endfunction : enc
  // preload a pair through the direct write port
  task automatic wr_acc(input logic [1:0] sel, input logic [63:0] hi, input logic [63:0] lo);
    @(posedge clk);
    #1;
    acc_wr_en = 1'b1;
    acc_wr_sel = sel;
    acc_wr_hi = hi;
    acc_wr_lo = lo;
    @(posedge clk);
    #1;
    acc_wr_en = 1'b0;
  endtask : wr_acc
  // issue and watch the addressed pair
  task automatic op(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b, input int n);
    acc_rd_sel = w[12:11];
    fdp_pipe_model_inst.issue(w, a, b, n);
  endtask : op
  task automatic acc_is(input logic [63:0] h, input logic [63:0] l);
    `CHK("acc_hi", h, acc_rd_hi)
    `CHK("acc_lo", l, acc_rd_lo)
  endtask : acc_is
  task automatic t_pair_half;
    op(enc(6'h30, 5'h04, 2'h1, 3'h0), 64'h8000_4000, 64'h8000_4000, 1);
    acc_is(64'h0, 64'hffffffff_9fffffff);
    `CHK("flag", 4'h2, ovf_flag)
  endtask : t_pair_half
  task automatic t_quad;
    op(enc(6'h34, 5'h04, 2'h2, 3'h0), {4{16'hc000}}, {4{16'h4000}}, 2);
    acc_is({64{1'b1}}, 64'hffffffff_00000000);
    flag_clr = 4'hf;
    op(enc(6'h34, 5'h04, 2'h2, 3'h0), 64'h0, 64'h5, 1);
    flag_clr = 4'h0;
    acc_is({64{1'b1}}, 64'hffffffff_00000000);
    `CHK("flag", 4'h0, ovf_flag)
  endtask : t_quad
  task automatic t_word;
    wr_acc(2'h3, 64'h0, 64'h7fffffff_ffffffff);
    op(enc(6'h34, 5'h0c, 2'h3, 3'h0), {2{32'h40000000}}, {2{32'h40000000}}, 1);
    acc_is(64'h0, 64'h7fffffff_ffffffff);
    op(enc(6'h34, 5'h0c, 2'h0, 3'h0), {2{32'h80000000}}, {2{32'h80000000}}, 1);
    acc_is(64'h0, 64'h7fffffff_ffffffff);
    wr_acc(2'h3, {64{1'b1}}, 64'h80000000_00000000);
    op(enc(6'h34, 5'h0c, 2'h3, 3'h0), {2{32'hc0000000}}, {2{32'h40000000}}, 1);
    acc_is({64{1'b1}}, 64'h80000000_00000000);
    `CHK("flag", 4'h9, ovf_flag)
  endtask : t_word
  // underflow, then minus one squared overflowing while all flags are cleared
  task automatic t_single;
    wr_acc(2'h1, 64'h90000000, 64'h0);
    op(enc(6'h30, 5'h0c, 2'h1, 3'h0), 64'hc0000000, 64'h40000000, 1);
    acc_is(64'hffffffff_80000000, 64'h0);
    `CHK("flag", 4'hb, ovf_flag)
    flag_clr = 4'hf;
    op(enc(6'h30, 5'h0c, 2'h0, 3'h0), 64'h80000000, 64'h80000000, 1);
    flag_clr = 4'h0;
    acc_is(64'h7fffffff, {64{1'b1}});
    `CHK("flag", 4'h1, ovf_flag)
  endtask : t_single
  task automatic t_exc;
    op(enc(6'h34, 5'h04, 2'h2, 3'h1), 64'h1, 64'h1, 1);
    `CHK("reserved", 1'b1, exc_reserved)
    dsp_enable = 1'b0;
    op(enc(6'h34, 5'h04, 2'h2, 3'h0), 64'h1, 64'h1, 1);
    dsp_enable = 1'b1;
    `CHK("disabled", 1'b1, exc_dsp_disabled)
    op(enc(6'h31, 5'h04, 2'h2, 3'h0), 64'h1, 64'h1, 1);
    `CHK("foreign", 2'b00, {exc_reserved, exc_dsp_disabled})
    acc_is({64{1'b1}}, 64'hffffffff_00000000);
  endtask : t_exc
  // reset in mid-run clears pairs and flags; work resumes right after release
  task automatic t_reset;
    arst_n = 1'b0;
    @(posedge clk);
    #1;
    `CHK("rst_flag", 4'h0, ovf_flag)
    acc_is(64'h0, 64'h0);
    @(posedge clk);
    #1;
    arst_n = 1'b1;
    op(enc(6'h34, 5'h04, 2'h3, 3'h0), 64'h8000, 64'h8000, 1);
    acc_is(64'h0, 64'h7fffffff);
    `CHK("flag", 4'h8, ovf_flag)
  endtask : t_reset
  // main sequence after eight cycles of reset
  initial begin
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    acc_is(64'h0, 64'h0);
    t_pair_half;
    t_quad;
    t_word;
    t_single;
    t_exc;
    t_reset;
    finish_test;
  end
  // watchdog well beyond the few dozen cycles the scenarios need
  initial begin
    #(40 * 2000);
    n_fail++;
    finish_test;
  end
  task automatic finish_test;
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
endmodule : fractional_dot_product_mac_bench

//--- verilog/fdp_defs.svh
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH

// instruction word fields
`define FDP_OPC_MSB 31
`define FDP_OPC_LSB 26
`define FDP_ZERO_MSB 15
`define FDP_ZERO_LSB 13
`define FDP_SEL_MSB 12
`define FDP_SEL_LSB 11
`define FDP_SUB_MSB 10
`define FDP_SUB_LSB 6
`define FDP_FUNC_MSB 5
`define FDP_FUNC_LSB 0

// field encodings
`define FDP_OPC_MAJOR 6'h1f
`define FDP_FUNC_GROUP_A 6'h30
`define FDP_FUNC_GROUP_B 6'h34
`define FDP_SUB_DOT 5'h04
`define FDP_SUB_SAT 5'h0c
`define FDP_ZERO_FIELD 3'h0

// overflow flag position inside the dsp control register
`define FDP_FLAG_LSB 16

// q63 saturation limits
`define FDP_Q63_MAX 64'h7fffffffffffffff
`define FDP_Q63_MIN 64'h8000000000000000

// reset values
`define FDP_ACC_RST 64'h0000000000000000
`define FDP_FLAG_RST 4'h0

`endif

//--- verilog/fdp_mac.sv
// Functional notes
// - q15 product doubled, minus-one squared saturates
// - saturation sets flag bit sixteen plus index
// - select field picks one of four pairs
// - pair halfword: sum products into the low words of both halves
// - pair halfword: halves written back sign-extended
// - quad halfword: 128-bit accumulate, no saturation
// - q31 word products doubled, minus-one squared saturates
// - pair word: saturate when sum bits 64,63 differ
// - single word: low words multiplied as q31
// - single word: 64-bit accumulate saturates both ways
// - no operand-dependent exceptions, only reserved/disabled
// - quad halfword decode: major, 110100, 00100
// - sub-operation 01100 picks word forms by function
// - three bits above select must be zero
`include "fdp_defs.svh"

module fdp_mac (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] src_one,
  input wire logic [63:0] src_two,
  input wire logic dsp_enable,
  // direct accumulator write from other instructions
  input wire logic acc_wr_en,
  input wire logic [1:0] acc_wr_sel,
  input wire logic [63:0] acc_wr_hi,
  input wire logic [63:0] acc_wr_lo,
  // accumulator read port
  input wire logic [1:0] acc_rd_sel,
  output logic [63:0] acc_rd_hi,
  output logic [63:0] acc_rd_lo,
  // overflow flags of the dsp control register
  input wire logic [3:0] flag_clr,
  output logic [3:0] ovf_flag,
  // exceptions
  output logic exc_reserved,
  output logic exc_dsp_disabled
);
  import fdp_pkg::*;

  fdp_state_s st;       // registered state
  fdp_state_s next_st;  // next state

  fdp_op_e op;          // decoded operation
  logic known;          // word belongs to this datapath
  logic [5:0] opc;      // major opcode field
  logic [5:0] func;     // function field
  logic [4:0] sub;      // sub-operation field
  logic [2:0] zero_f;   // must-be-zero field
  logic [1:0] sel;      // sum_register_select
  logic [63:0] cur_hi;  // selected upper half
  logic [63:0] cur_lo;  // selected bottom half
  logic [63:0] ph_sum;  // pair halfword dot product
  logic [63:0] ph_acc;  // pair halfword accumulate
  logic [63:0] qh_sum;  // quad halfword dot product
  logic [127:0] qh_acc; // quad halfword accumulate
  logic [127:0] pw_dot; // pair word dot product
  logic [128:0] pw_t;   // pair word widened sum
  logic [64:0] w_t;     // single word widened sum
  logic [63:0] w_clamp; // single word q63 limit picked by the guard bit
  logic set_flag;       // a saturation happened this cycle

  // products of the four halfword lanes and the two word lanes
  logic [3:0][31:0] p15;
  logic [3:0] s15;
  logic [1:0][63:0] p31;
  logic [1:0] s31;

  // field split of the instruction word
  assign opc = instr_word[`FDP_OPC_MSB:`FDP_OPC_LSB];
  assign func = instr_word[`FDP_FUNC_MSB:`FDP_FUNC_LSB];
  assign sub = instr_word[`FDP_SUB_MSB:`FDP_SUB_LSB];
  assign zero_f = instr_word[`FDP_ZERO_MSB:`FDP_ZERO_LSB];
  assign sel = instr_word[`FDP_SEL_MSB:`FDP_SEL_LSB];

  // halfword multipliers, one per lane
  for (genvar g = 0; g < 4; g++) begin : g_h
    fdp_mul_if #(.W(16)) mi ();
    assign mi.a = src_one[16*g +: 16];
    assign mi.b = src_two[16*g +: 16];
    fdp_qmul #(.W(16)) u_mul (
      .m(mi)
    );
    assign p15[g] = mi.prod;
    assign s15[g] = mi.sat;
  end

  // word multipliers; lane 0 also serves the single-word form
  for (genvar g = 0; g < 2; g++) begin : g_w
    fdp_mul_if #(.W(32)) mi ();
    assign mi.a = src_one[32*g +: 32];
    assign mi.b = src_two[32*g +: 32];
    fdp_qmul #(.W(32)) u_mul (
      .m(mi)
    );
    assign p31[g] = mi.prod;
    assign s31[g] = mi.sat;
  end

  // decode: only our own words are claimed, others pass untouched
  always_comb begin
    op = FDP_OP_NONE;
    known = 1'b0;
    if (opc != `FDP_OPC_MAJOR) begin
      known = 1'b0;
    end else if (func == `FDP_FUNC_GROUP_B && sub == `FDP_SUB_DOT) begin
      known = 1'b1;
      op = FDP_OP_QH;
    end else if (func == `FDP_FUNC_GROUP_B && sub == `FDP_SUB_SAT) begin
      known = 1'b1;
      op = FDP_OP_PW;
    end else if (func == `FDP_FUNC_GROUP_A && sub == `FDP_SUB_SAT) begin
      known = 1'b1;
      op = FDP_OP_W;
    end else if (func == `FDP_FUNC_GROUP_A && sub == `FDP_SUB_DOT) begin
      known = 1'b1;
      op = FDP_OP_PH;
    end
    // a non-zero pad field or a disabled unit kills the operation
    if (!instr_valid || zero_f != `FDP_ZERO_FIELD || !dsp_enable) begin
      op = FDP_OP_NONE;
    end
  end

  // arithmetic of all four forms, computed in parallel
  always_comb begin
    cur_hi = st.hi[sel];
    cur_lo = st.lo[sel];
    // pair halfword: low 32 bits of each half form the accumulator
    ph_sum = {{32{p15[1][31]}}, p15[1]} + {{32{p15[0][31]}}, p15[0]};
    ph_acc = {cur_hi[31:0], cur_lo[31:0]} + ph_sum;
    // quad halfword: plain wrap of the full 128 bits
    qh_sum = {{32{p15[3][31]}}, p15[3]} + {{32{p15[2][31]}}, p15[2]}
           + {{32{p15[1][31]}}, p15[1]} + {{32{p15[0][31]}}, p15[0]};
    qh_acc = {cur_hi, cur_lo} + {{64{qh_sum[63]}}, qh_sum};
    // pair word: one guard bit exposes q63 overflow
    pw_dot = {{64{p31[1][63]}}, p31[1]} + {{64{p31[0][63]}}, p31[0]};
    pw_t = {cur_hi[63], cur_hi, cur_lo} + {pw_dot[127], pw_dot};
    // single word: 64-bit accumulator with one guard bit
    w_t = {cur_hi[31], cur_hi[31:0], cur_lo[31:0]} + {p31[0][63], p31[0]};
    // clamp first and split after, so both halves come from one q63 limit
    w_clamp = w_t[64] ? `FDP_Q63_MIN : `FDP_Q63_MAX;
  end

  // next state
  always_comb begin
    next_st = st;
    set_flag = 1'b0;
    // direct writes from other instructions; our own result wins below
    if (acc_wr_en) begin
      next_st.hi[acc_wr_sel] = acc_wr_hi;
      next_st.lo[acc_wr_sel] = acc_wr_lo;
    end
    case (op)
      FDP_OP_PH: begin
        next_st.hi[sel] = {{32{ph_acc[63]}}, ph_acc[63:32]};
        next_st.lo[sel] = {{32{ph_acc[31]}}, ph_acc[31:0]};
        set_flag = s15[1] | s15[0];
      end
      FDP_OP_QH: begin
        next_st.hi[sel] = qh_acc[127:64];
        next_st.lo[sel] = qh_acc[63:0];
        set_flag = |s15;
      end
      FDP_OP_PW: begin
        set_flag = |s31;
        if (pw_t[64] != pw_t[63]) begin
          // overflow past q63: clamp to the signed limit
          next_st.hi[sel] = pw_t[64] ? {64{1'b1}} : `FDP_ACC_RST;
          next_st.lo[sel] = pw_t[64] ? `FDP_Q63_MIN : `FDP_Q63_MAX;
          set_flag = 1'b1;
        end else begin
          next_st.hi[sel] = pw_t[127:64];
          next_st.lo[sel] = pw_t[63:0];
        end
      end
      FDP_OP_W: begin
        set_flag = s31[0];
        if (w_t[64] != w_t[63]) begin
          // sign of the guard bit tells overflow from underflow
          // each 32-bit half of the limit is written back sign-extended
          next_st.hi[sel] = {{32{w_clamp[63]}}, w_clamp[63:32]};
          next_st.lo[sel] = {{32{w_clamp[31]}}, w_clamp[31:0]};
          set_flag = 1'b1;
        end else begin
          next_st.hi[sel] = {{32{w_t[63]}}, w_t[63:32]};
          next_st.lo[sel] = {{32{w_t[31]}}, w_t[31:0]};
        end
      end
      default: begin
        set_flag = 1'b0;  // idle slot or foreign word
      end
    endcase
    // flags are sticky; a set in the clearing cycle wins
    next_st.flag = (st.flag & ~flag_clr) | (set_flag ? 4'(4'h1 << sel) : `FDP_FLAG_RST);
    // read port shows the value after this cycle's update, so no stall
    next_st.rd_hi = next_st.hi[acc_rd_sel];
    next_st.rd_lo = next_st.lo[acc_rd_sel];
    // only decode-level exceptions exist; data never traps
    next_st.rsvd = instr_valid && known && (zero_f != `FDP_ZERO_FIELD);
    next_st.dis = instr_valid && known && !dsp_enable
                  && (zero_f == `FDP_ZERO_FIELD);
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  assign acc_rd_hi = st.rd_hi;
  assign acc_rd_lo = st.rd_lo;
  assign ovf_flag = st.flag;
  assign exc_reserved = st.rsvd;
  assign exc_dsp_disabled = st.dis;

endmodule : fdp_mac

//--- verilog/fdp_mul_if.sv
interface fdp_mul_if #(parameter int W = 16);
  logic [W-1:0] a;       // multiplicand
  logic [W-1:0] b;       // multiplier
  logic [2*W-1:0] prod;  // doubled fractional product
  logic sat;             // product was forced to maximum
  modport calc (input a, input b, output prod, output sat);
  modport user (output a, output b, input prod, input sat);
endinterface : fdp_mul_if

//--- verilog/fdp_pkg.sv
package fdp_pkg;

  // decoded operation of the current issue slot
  typedef enum logic [2:0] {
    FDP_OP_NONE = 3'b000,
    FDP_OP_PH = 3'b001,
    FDP_OP_QH = 3'b010,
    FDP_OP_PW = 3'b011,
    FDP_OP_W = 3'b100
  } fdp_op_e;

  // whole state of the datapath
  typedef struct packed {
    logic [3:0][63:0] hi;  // upper_half_accum per pair
    logic [3:0][63:0] lo;  // bottom_half_accum per pair
    logic [3:0] flag;      // overflow flags, control bits 16..19
    logic [63:0] rd_hi;    // registered read port
    logic [63:0] rd_lo;
    logic rsvd;            // reserved-instruction pulse
    logic dis;             // dsp-disabled pulse
  } fdp_state_s;

endpackage : fdp_pkg

//--- verilog/fdp_qmul.sv
// signed fractional multiply, product shifted left by one bit
module fdp_qmul #(parameter int W = 16) (
  // operand and result bundle
  fdp_mul_if.calc m
);
  // minus one in q format: only this pair overflows the shifted product
  localparam logic [W-1:0] MINUS_ONE = {1'b1, {(W-1){1'b0}}};

  logic signed [2*W-1:0] full;  // raw signed product

  assign full = $signed(m.a) * $signed(m.b);
  // both operands at minus one would give plus one, which q format lacks
  assign m.sat = (m.a == MINUS_ONE) && (m.b == MINUS_ONE);
  assign m.prod = m.sat ? {1'b0, {(2*W-1){1'b1}}} : {full[2*W-2:0], 1'b0};
endmodule : fdp_qmul
